// *** rt_handshake_regs.sv ***
// Purpose: Register bank mirroring connection-control and IO words for the host
// Assumes: Frame inputs come from logic on core_clk; phase value is synchronous
// Notes: Transmitted new-data toggles once per tx_data_changed strobe, except in a phase-four entry cycle, which clears it
`timescale 1ns/100ps
module rt_handshake_regs
  import rt_handshake_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire reg_req_t bus_req,
  output logic [15:0] rdata,
  input wire master_frame_t master_frame,
  input wire logic [2:0] comm_phase,
  input wire logic tx_data_changed,
  input wire logic slave_reply_frame,
  output logic [15:0] tx_conn_word,
  output logic [15:0] tx_io_status
);

  // ==========================================
  // State and next values
  logic [15:0] rx_connection_control, next_rx_connection_control;
  logic [15:0] rx_io_control, next_rx_io_control;
  logic [15:0] tx_connection_control, next_tx_connection_control;
  logic [15:0] io_status, next_io_status;
  logic [15:0] next_rdata, next_tx_conn_word, next_tx_io_status;
  phase_t phase, next_phase;

  function automatic logic [15:0] fix_conn(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[BIT_SYNC] = 1'b1;
    return r;
  endfunction

  // ==========================================
  // Phase tracking
  // High for the one cycle in which the registered phase steps into phase four
  logic phase_entry;

  always_comb begin
    next_phase = (comm_phase == PHASE_FOUR_CODE) ? PH_FOUR : PH_INIT;
    phase_entry = (next_phase == PH_FOUR) && (phase != PH_FOUR);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= PH_INIT;
    end else begin
      phase <= next_phase;
    end
  end

  // ==========================================
  // Received words
  always_comb begin
    next_rx_connection_control = rx_connection_control;
    next_rx_io_control = rx_io_control;
    if (master_frame.valid) begin
      next_rx_connection_control = fix_conn(master_frame.conn);
      if (phase == PH_FOUR) begin
        next_rx_connection_control[BIT_PROD_READY] = 1'b1;
      end
      // Only bit 15 is meaningful; everything else forced to zero
      next_rx_io_control = master_frame.ioctl[BIT_OUT_STATE] ? IOCTL_ACTIVE : IOCTL_INACTIVE;
    end
    // Entry clear comes last so it wins over a frame in the same cycle
    if (phase_entry) begin
      next_rx_connection_control[BIT_NEW_DATA] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_connection_control <= CONN_RESET;
      rx_io_control <= IOCTL_INACTIVE;
    end else begin
      rx_connection_control <= next_rx_connection_control;
      rx_io_control <= next_rx_io_control;
    end
  end

  // ==========================================
  // Host-maintained words
  always_comb begin
    next_tx_connection_control = tx_connection_control;
    next_io_status = io_status;
    // Host writes take effect first so hardware events below win the same cycle
    if (bus_req.wr) begin
      if (bus_req.addr == ADDR_TX_CONN) begin
        next_tx_connection_control[BIT_PROD_READY] = bus_req.wdata[BIT_PROD_READY];
      end else if (bus_req.addr == ADDR_TX_IOSTAT) begin
        next_io_status = bus_req.wdata;
      end
    end
    if (tx_data_changed) begin
      next_tx_connection_control[BIT_NEW_DATA] = ~tx_connection_control[BIT_NEW_DATA];
    end
    if (phase_entry) begin
      next_tx_connection_control[BIT_NEW_DATA] = 1'b0;
    end
    next_tx_connection_control = fix_conn(next_tx_connection_control);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_connection_control <= CONN_RESET;
      io_status <= STAT_RESET;
    end else begin
      tx_connection_control <= next_tx_connection_control;
      io_status <= next_io_status;
    end
  end

  // ==========================================
  // Slave reply frame words
  always_comb begin
    next_tx_conn_word = tx_conn_word;
    next_tx_io_status = tx_io_status;
    if (slave_reply_frame) begin
      next_tx_conn_word = tx_connection_control;
      next_tx_io_status = io_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_conn_word <= CONN_RESET;
      tx_io_status <= STAT_RESET;
    end else begin
      tx_conn_word <= next_tx_conn_word;
      tx_io_status <= next_tx_io_status;
    end
  end

  // ==========================================
  // Read port
  always_comb begin
    // Unmapped addresses read as zero
    next_rdata = 16'h0000;
    if (bus_req.rd) begin
      if (bus_req.addr == ADDR_RX_CONN) begin
        next_rdata = rx_connection_control;
      end else if (bus_req.addr == ADDR_RX_IOCTL) begin
        next_rdata = rx_io_control;
      end else if (bus_req.addr == ADDR_TX_CONN) begin
        next_rdata = tx_connection_control;
      end else if (bus_req.addr == ADDR_TX_IOSTAT) begin
        next_rdata = io_status;
      end else if (bus_req.addr == ADDR_PHASE) begin
        next_rdata = {15'h0000, phase == PH_FOUR};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // Checks
  chk_sync_bit_set: assert property (@(posedge core_clk) disable iff (rst)
    rx_connection_control[BIT_SYNC] && tx_connection_control[BIT_SYNC])
    else $error("sync bit not set");
  chk_ioctl_clean: assert property (@(posedge core_clk) disable iff (rst)
    (rx_io_control == IOCTL_ACTIVE) || (rx_io_control == IOCTL_INACTIVE))
    else $error("io control has stray bits");
  chk_ioctl_mirror: assert property (@(posedge core_clk) disable iff (rst)
    master_frame.valid |=> rx_io_control[BIT_OUT_STATE] == $past(master_frame.ioctl[BIT_OUT_STATE]))
    else $error("io control not mirrored");
  chk_ready_phase4: assert property (@(posedge core_clk) disable iff (rst)
    master_frame.valid && phase == PH_FOUR |=> rx_connection_control[BIT_PROD_READY])
    else $error("producer ready not set");
  chk_newdata_clear: assert property (@(posedge core_clk) disable iff (rst)
    phase == PH_INIT ##1 phase == PH_FOUR |-> !rx_connection_control[BIT_NEW_DATA])
    else $error("new data not cleared on phase four entry");
  chk_tx_toggle: assert property (@(posedge core_clk) disable iff (rst)
    tx_data_changed && !(comm_phase == PHASE_FOUR_CODE && phase != PH_FOUR)
      |=> tx_connection_control[BIT_NEW_DATA] != $past(tx_connection_control[BIT_NEW_DATA]))
    else $error("new data bit did not toggle");
  chk_status_sent: assert property (@(posedge core_clk) disable iff (rst)
    slave_reply_frame |=> tx_io_status == $past(io_status))
    else $error("io status not sent");
  chk_rx_conn_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.rd && bus_req.addr == ADDR_RX_CONN |=> rdata == $past(rx_connection_control))
    else $error("connection word read wrong");
  cov_full_op: cover property (@(posedge core_clk) io_status == 16'hc000 && slave_reply_frame);
  cov_enter_four: cover property (@(posedge core_clk) phase == PH_INIT ##1 phase == PH_FOUR);
  cov_active_out: cover property (@(posedge core_clk) rx_io_control == IOCTL_ACTIVE);
  cov_tx_toggle: cover property (@(posedge core_clk) tx_data_changed && !phase_entry);
  cov_write_ready: cover property (@(posedge core_clk) bus_req.wr && bus_req.addr == ADDR_TX_CONN);

  // ==========================================
  // Read port checks
  chk_ioctl_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.rd && bus_req.addr == ADDR_RX_IOCTL
      |=> rdata == $past(rx_io_control))
    else $error("io control read wrong");

  chk_tx_conn_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.rd && bus_req.addr == ADDR_TX_CONN
      |=> rdata == $past(tx_connection_control))
    else $error("transmitted connection word read wrong");

  chk_status_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.rd && bus_req.addr == ADDR_TX_IOSTAT
      |=> rdata == $past(io_status))
    else $error("io status read wrong");

  chk_phase_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.rd && bus_req.addr == ADDR_PHASE
      |=> rdata == {15'h0000, $past(phase) == PH_FOUR})
    else $error("phase read wrong");

  chk_idle_rdata: assert property (@(posedge core_clk) disable iff (rst)
    !bus_req.rd
      |=> rdata == 16'h0000)
    else $error("read data not zero outside a read");

  chk_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.rd && bus_req.addr != ADDR_RX_CONN && bus_req.addr != ADDR_RX_IOCTL && bus_req.addr != ADDR_TX_CONN
      && bus_req.addr != ADDR_TX_IOSTAT && bus_req.addr != ADDR_PHASE |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  // ==========================================
  // Received word checks
  chk_rx_conn_hold: assert property (@(posedge core_clk) disable iff (rst)
    !master_frame.valid && !phase_entry
      |=> $stable(rx_connection_control))
    else $error("received connection word changed without a frame");

  chk_ioctl_hold: assert property (@(posedge core_clk) disable iff (rst)
    !master_frame.valid
      |=> $stable(rx_io_control))
    else $error("io control changed without a frame");

  chk_rx_conn_mirror: assert property (@(posedge core_clk) disable iff (rst)
    master_frame.valid
      |=> rx_connection_control[15:4] == $past(master_frame.conn[15:4]) && rx_connection_control[2] == $past(master_frame.conn[2]))
    else $error("connection word not mirrored");

  chk_newdata_mirror: assert property (@(posedge core_clk) disable iff (rst)
    master_frame.valid && !phase_entry
      |=> rx_connection_control[BIT_NEW_DATA] == $past(master_frame.conn[BIT_NEW_DATA]))
    else $error("new data bit not mirrored");

  chk_ready_mirror: assert property (@(posedge core_clk) disable iff (rst)
    master_frame.valid && phase != PH_FOUR
      |=> rx_connection_control[BIT_PROD_READY] == $past(master_frame.conn[BIT_PROD_READY]))
    else $error("producer ready not mirrored outside phase four");

  chk_rx_entry_clear: assert property (@(posedge core_clk) disable iff (rst)
    phase_entry
      |=> !rx_connection_control[BIT_NEW_DATA])
    else $error("received new data not cleared on entry");

  // ==========================================
  // Host word checks
  chk_tx_fixed_bits: assert property (@(posedge core_clk) disable iff (rst)
    tx_connection_control[15:4] == 12'h000 && !tx_connection_control[2])
    else $error("stray bits in transmitted connection word");

  chk_tx_ready_write: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.wr && bus_req.addr == ADDR_TX_CONN
      |=> tx_connection_control[BIT_PROD_READY] == $past(bus_req.wdata[BIT_PROD_READY]))
    else $error("producer ready write lost");

  chk_tx_ready_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(bus_req.wr && bus_req.addr == ADDR_TX_CONN)
      |=> $stable(tx_connection_control[BIT_PROD_READY]))
    else $error("producer ready changed without a write");

  chk_tx_newdata_hold: assert property (@(posedge core_clk) disable iff (rst)
    !tx_data_changed && !phase_entry
      |=> $stable(tx_connection_control[BIT_NEW_DATA]))
    else $error("new data bit changed without cause");

  chk_tx_entry_clear: assert property (@(posedge core_clk) disable iff (rst)
    phase_entry
      |=> !tx_connection_control[BIT_NEW_DATA])
    else $error("transmitted new data not cleared on entry");

  chk_status_write: assert property (@(posedge core_clk) disable iff (rst)
    bus_req.wr && bus_req.addr == ADDR_TX_IOSTAT
      |=> io_status == $past(bus_req.wdata))
    else $error("io status write lost");

  chk_status_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(bus_req.wr && bus_req.addr == ADDR_TX_IOSTAT)
      |=> $stable(io_status))
    else $error("io status changed without a write");

  // ==========================================
  // Slave reply and phase checks
  chk_conn_sent: assert property (@(posedge core_clk) disable iff (rst)
    slave_reply_frame
      |=> tx_conn_word == $past(tx_connection_control))
    else $error("connection word not sent");

  chk_words_hold: assert property (@(posedge core_clk) disable iff (rst)
    !slave_reply_frame
      |=> $stable(tx_conn_word) && $stable(tx_io_status))
    else $error("sent words changed without a reply frame");

  chk_sent_sync_bit: assert property (@(posedge core_clk) disable iff (rst)
    tx_conn_word[BIT_SYNC])
    else $error("sent connection word lacks sync bit");

  chk_phase_follow: assert property (@(posedge core_clk) disable iff (rst)
    1'b1
      |=> (phase == PH_FOUR) == ($past(comm_phase) == PHASE_FOUR_CODE))
    else $error("phase does not follow input");

  chk_phase_legal: assert property (@(posedge core_clk) disable iff (rst)
    phase == PH_INIT || phase == PH_FOUR)
    else $error("phase register holds an illegal code");
endmodule

// *** rt_handshake_pkg.sv ***
// Purpose: Constants and carriers for the real-time handshake register bank
// Assumes: 16-bit registers, register numbers used directly as addresses
// Notes: Frame-side events arrive as single-cycle strobes from the protocol engine
package rt_handshake_pkg;
  // ==========================================
  // Register map
  localparam logic [11:0] ADDR_RX_CONN = 12'h3e8;
  localparam logic [11:0] ADDR_RX_IOCTL = 12'h3e9;
  localparam logic [11:0] ADDR_TX_CONN = 12'h7d0;
  localparam logic [11:0] ADDR_TX_IOSTAT = 12'h7d1;
  localparam logic [11:0] ADDR_PHASE = 12'h7ff;
  // ==========================================
  // Fields
  localparam int BIT_PROD_READY = 0;
  localparam int BIT_NEW_DATA = 1;
  localparam int BIT_SYNC = 3;
  localparam int BIT_OUT_STATE = 15;
  localparam logic [15:0] IOCTL_ACTIVE = 16'h8000;
  localparam logic [15:0] IOCTL_INACTIVE = 16'h0000;
  localparam logic [15:0] CONN_RESET = 16'h0008;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [2:0] PHASE_FOUR_CODE = 3'h4;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] conn;
    logic [15:0] ioctl;
  } master_frame_t;

  typedef enum logic [1:0] {
    PH_INIT = 2'b00,
    PH_FOUR = 2'b01
  } phase_t;
endpackage

// *** frame_engine_model.sv ***
// Purpose: Frame-side model of the protocol engine that feeds the handshake bank
// Assumes: Events are one-cycle pulses on core_clk, phase is a level
// Notes: Signals change by non-blocking assignment after a rising edge, apart from the blocking time-zero initial values
`timescale 1ns/100ps
module frame_engine_model
  import rt_handshake_pkg::*;
(
  input wire logic core_clk,
  output master_frame_t master_frame,
  output logic [2:0] comm_phase,
  output logic tx_data_changed,
  output logic slave_reply_frame
);
  // ==========================================
  // Event tasks
  initial begin
    master_frame = '0;
    comm_phase = 3'h0;
    tx_data_changed = 1'b0;
    slave_reply_frame = 1'b0;
  end
  task automatic frame(input logic [15:0] conn, input logic [15:0] ioctl);
    @(posedge core_clk);
    master_frame <= '{valid: 1'b1, conn: conn, ioctl: ioctl};
    @(posedge core_clk);
    master_frame.valid <= 1'b0;
  endtask
  // Reply high builds a slave reply frame, low reports changed data
  task automatic pulse(input logic reply);
    @(posedge core_clk);
    if (reply) slave_reply_frame <= 1'b1;
    else tx_data_changed <= 1'b1;
    @(posedge core_clk);
    slave_reply_frame <= 1'b0;
    tx_data_changed <= 1'b0;
  endtask
  // Two edges let the registered phase settle before the next event
  task automatic set_phase(input logic [2:0] p);
    @(posedge core_clk);
    comm_phase <= p;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// *** rt_handshake_regs_tb.sv ***
// Purpose: Self-checking bench for the handshake register bank
// Assumes: Register reads answer one cycle after the strobe
// Notes: Frame events come from the frame engine model
`timescale 1ns/100ps
module rt_handshake_regs_tb;
  import rt_handshake_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t bus_req = '0;
  logic [15:0] rdata, tx_conn_word, tx_io_status;
  master_frame_t master_frame;
  logic [2:0] comm_phase;
  logic tx_data_changed, slave_reply_frame;
  int err_total = 0;
  int n_tests = 0;
  rt_handshake_regs rt_handshake_regs_i(.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .master_frame(master_frame), .comm_phase(comm_phase), .tx_data_changed(tx_data_changed),
    .slave_reply_frame(slave_reply_frame), .tx_conn_word(tx_conn_word), .tx_io_status(tx_io_status));
  frame_engine_model frame_engine_model_i(.core_clk(core_clk), .master_frame(master_frame),
    .comm_phase(comm_phase), .tx_data_changed(tx_data_changed), .slave_reply_frame(slave_reply_frame));
  // ==========================================
  // Bus, compare and wrap-up tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd_check(input logic [11:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog and tests
  initial forever #2.5 core_clk = ~core_clk;
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd_check(ADDR_RX_CONN, CONN_RESET);
    rd_check(ADDR_RX_IOCTL, IOCTL_INACTIVE);
    rd_check(ADDR_TX_CONN, CONN_RESET);
    $display("test reset values done");
    frame_engine_model_i.frame(16'h0000, 16'hffff);
    rd_check(ADDR_RX_IOCTL, IOCTL_ACTIVE);
    frame_engine_model_i.frame(16'h0002, 16'h7fff);
    rd_check(ADDR_RX_IOCTL, IOCTL_INACTIVE);
    rd_check(ADDR_RX_CONN, 16'h000a);
    $display("test master frame mirror done");
    frame_engine_model_i.set_phase(PHASE_FOUR_CODE);
    rd_check(ADDR_RX_CONN, 16'h0008);
    rd_check(ADDR_PHASE, 16'h0001);
    frame_engine_model_i.frame(16'h0000, 16'h8000);
    rd_check(ADDR_RX_CONN, 16'h0009);
    $display("test phase four done");
    wr(ADDR_TX_CONN, 16'hfffe);
    rd_check(ADDR_TX_CONN, 16'h0008);
    wr(ADDR_TX_CONN, 16'h0001);
    rd_check(ADDR_TX_CONN, 16'h0009);
    frame_engine_model_i.pulse(1'b0);
    rd_check(ADDR_TX_CONN, 16'h000b);
    wr(ADDR_TX_IOSTAT, 16'hc000);
    wr(ADDR_RX_CONN, 16'hffff);
    wr(12'h123, 16'hffff);
    rd_check(12'h123, 16'h0000);
    rd_check(ADDR_TX_IOSTAT, 16'hc000);
    rd_check(ADDR_RX_CONN, 16'h0009);
    frame_engine_model_i.pulse(1'b1);
    #1 check(tx_conn_word, 16'h000b);
    check(tx_io_status, 16'hc000);
    wr(ADDR_TX_IOSTAT, 16'h4000);
    frame_engine_model_i.pulse(1'b1);
    #1 check(tx_io_status, 16'h4000);
    frame_engine_model_i.set_phase(3'h0);
    frame_engine_model_i.set_phase(PHASE_FOUR_CODE);
    rd_check(ADDR_TX_CONN, 16'h0009);
    $display("test slave reply done");
    wrap_up();
  end
endmodule
